// ---- dv/ddr3_ctrl_model.sv ----
// Controller model that issues commands to the device at falling edges.
`default_nettype none
module ddr3_ctrl_model
    import ddr3_calib_pkg::*;
(
    input  wire logic        mclk,
    output var  logic [3:0]  cmd,
    output var  logic [2:0]  ba,
    output var  logic [13:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Command spacing kept by the controller, in clocks.
    // ------------------------------------------------------------------
    localparam int T_RCD = 4;
    localparam int T_CCD = 4;
    localparam int T_RRD = 4;
    localparam int T_RC  = 10;
    localparam int T_FAW = 16;
    int          cyc       = 0;
    int          last_act  = -1000;
    int          last_rd   = -1000;
    int          last_wr   = -1000;
    logic [2:0]  last_bank = 3'h0;
    int          act_hist [4] = '{-1000, -1000, -1000, -1000};
    int          act_ptr   = 0;
    // Free-running cycle count that the spacing rules are measured against.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end
    // Start with the bus idle.
    initial begin
        cmd  = CMD_NOP;
        ba   = 3'h0;
        addr = 14'h0000;
    end
    // command and address
    // One command per call; address lines are inverted afterwards so that stale values never look valid.
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge mclk);
        // column commands wait for row and column spacing
        while ((c == CMD_RD || c == CMD_WR) && cyc - last_act < T_RCD) begin
            @(negedge mclk);
        end
        while ((c == CMD_RD && cyc - last_rd < T_CCD) || (c == CMD_WR && cyc - last_wr < T_CCD)) begin
            @(negedge mclk);
        end
        // activates spaced per bank, four per window at most
        while (c == CMD_ACT && (cyc - last_act < (b == last_bank ? T_RC : T_RRD)
                                || cyc - act_hist[act_ptr] < T_FAW)) begin
            @(negedge mclk);
        end
        if (c == CMD_ACT) begin
            act_hist[act_ptr] = cyc;
            act_ptr           = (act_ptr + 1) % 4;
            last_act          = cyc;
            last_bank         = b;
        end
        if (c == CMD_RD) begin
            last_rd = cyc;
        end
        if (c == CMD_WR) begin
            last_wr = cyc;
        end
        cmd  = c;
        ba   = b;
        addr = a;
        @(negedge mclk);
        cmd  = CMD_NOP;
        ba   = ~b;
        addr = ~a;
    endtask
    // one rank, no self refresh, bus idle while calibrating
    // Keep the channel quiet for the given number of cycles.
    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench for the calibration and mode register device block.
`default_nettype none
module testbench
    import ddr3_calib_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RL = 5;
    logic        mclk;
    logic        nrst;
    logic        all_lines;
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe, readout_active, array_read, array_write, zq_busy, zq_long;
    logic [13:0] mr0_val, mr1_val, mr2_val, mr3_val;
    logic [13:0] mr_seen [4];
    int          bad_count = 0;
    int          cmp_count = 0;
    // ------------------------------------------------------------------
    // Clock, reset, device and controller model
    // ------------------------------------------------------------------
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    always_comb mr_seen = '{mr0_val, mr1_val, mr2_val, mr3_val};
    ddr3_calib_dev #(.ZQL_CYC(16), .ZQS_CYC(8)) u_ddr3_calib_dev (
        .mclk(mclk), .nrst(nrst), .cmd(cmd), .ba(ba), .addr(addr), .all_lines(all_lines),
        .dq_out(dq_out), .dq_oe(dq_oe), .readout_active(readout_active), .array_read(array_read),
        .array_write(array_write), .zq_busy(zq_busy), .zq_long(zq_long),
        .mr0_val(mr0_val), .mr1_val(mr1_val), .mr2_val(mr2_val), .mr3_val(mr3_val));
    ddr3_ctrl_model ctrl (.mclk(mclk), .cmd(cmd), .ba(ba), .addr(addr));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare one value and count it.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Issue a read and follow every cycle of the expected burst window.
    task automatic burst(input logic [13:0] a, input int beats, input logic on);
        int         k;
        logic       live;
        logic       bit_v;
        ctrl.issue(CMD_RD, {a[12], a[2], 1'b1}, a);
        for (k = 1; k <= RL + 9; k++) begin
            @(negedge mclk);
            live  = on && k > RL && k <= RL + beats;
            bit_v = MPR_PATTERN[(k - RL - 1 + (a[2] ? 4 : 0)) & 7];
            check("dq_oe", {15'h0, dq_oe}, {15'h0, live});
            if (live) begin
                check("dq_out", {8'h0, dq_out}, all_lines ? {8'h0, {8{bit_v}}} : {15'h0, bit_v});
            end
        end
    endtask
    task automatic mr3_set(input logic [13:0] v);
        ctrl.issue(CMD_MRS, BA_MR3, v);
        check("mr3_val", {2'h0, mr3_val}, {2'h0, v});
        ctrl.settle(14);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        int i;
        for (i = 0; i < 4; i++) check("mr_val", {2'h0, mr_seen[i]}, 16'h0000);
        check("flags", {10'h0, dq_oe, readout_active, array_read, array_write, zq_busy, zq_long}, 16'h0000);
    endtask
    task automatic t_mrs;
        logic [13:0] vals [3];
        int          i;
        vals = '{14'h0103, 14'h0044, 14'h0018};
        for (i = 0; i < 3; i++) begin
            ctrl.issue(CMD_MRS, 3'(i), vals[i]);
            check("mr_val", {2'h0, mr_seen[i]}, {2'h0, vals[i]});
        end
        check("mr3_val", {2'h0, mr3_val}, 16'h0000);
    endtask
    task automatic t_readout;
        ctrl.issue(CMD_MRS, BA_MR3, 14'h0004);
        ctrl.settle(5);
        check("readout_early", {15'h0, readout_active}, 16'h0000);
        ctrl.settle(9);
        check("readout_on", {15'h0, readout_active}, 16'h0001);
        all_lines = 1'b1;
        burst(14'h1000, 8, 1'b1);
        all_lines = 1'b0;
        burst(14'h0000, 4, 1'b1);
        burst(14'h0004, 4, 1'b1);
        // only reads while enabled; one write probes the refusal
        ctrl.issue(CMD_WR, 3'h6, 14'h0000);
        check("write_blocked", {15'h0, array_write}, 16'h0000);
        ctrl.settle(4);
        mr3_set(14'h0000);
        check("readout_off", {15'h0, readout_active}, 16'h0000);
        ctrl.issue(CMD_ACT, 3'h1, 14'h0123);
        check("act_quiet", {14'h0, array_read, array_write}, 16'h0000);
        ctrl.issue(CMD_WR, 3'h1, 14'h0000);
        check("array_write", {15'h0, array_write}, 16'h0001);
        ctrl.issue(CMD_RD, 3'h0, 14'h1000);
        check("array_read", {15'h0, array_read}, 16'h0001);
        ctrl.settle(12);
    endtask
    task automatic t_reserved;
        logic [13:0] v;
        int          i;
        for (i = 1; i < 4; i++) begin
            v = 14'h0004 | 14'(i);
            mr3_set(v);
            burst(14'h1000, 8, 1'b0);
        end
        mr3_set(14'h0000);
    endtask
    task automatic t_zq;
        int i;
        for (i = 0; i < 2; i++) begin
            ctrl.issue(CMD_ZQ, 3'(i), i[0] ? 14'h0400 : 14'h0000);
            ctrl.settle(1);
            check("zq_busy", {15'h0, zq_busy}, 16'h0001);
            check("zq_long", {15'h0, zq_long}, {15'h0, i[0]});
            ctrl.settle(i[0] ? 20 : 12);
            check("zq_done", {15'h0, zq_busy}, 16'h0000);
        end
    endtask
    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cut a hang short well after the expected run of about 280 cycles.
    initial begin
        #(25 * 4000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        nrst      = 1'b0;
        all_lines = 1'b0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        $display("test reset done");
        t_mrs();
        $display("test mode set done");
        t_readout();
        $display("test readout done");
        t_reserved();
        $display("test reserved done");
        t_zq();
        $display("test calibration done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- rtl/ddr3_calib_dev.sv ----
// Device-side command decoder with calibration readout, mode registers and ZQ.
`default_nettype none
module ddr3_calib_dev
    import ddr3_calib_pkg::*;
#(
    parameter int DQ_W    = 8,
    parameter int ZQL_CYC = TZQOPER_CYC,
    parameter int ZQS_CYC = TZQCS_CYC
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic [3:0]        cmd,
    input  wire logic [2:0]        ba,
    input  wire logic [13:0]       addr,
    input  wire logic              all_lines,
    output logic      [DQ_W-1:0]   dq_out,
    output logic                   dq_oe,
    output logic                   readout_active,
    output logic                   array_read,
    output logic                   array_write,
    output logic                   zq_busy,
    output logic                   zq_long,
    output logic      [13:0]       mr0_val,
    output logic      [13:0]       mr1_val,
    output logic      [13:0]       mr2_val,
    output logic      [13:0]       mr3_val
);
    // ------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0][13:0] mr;
        seq_t             st;
        logic [15:0]      cnt;
        logic [2:0]       beat;
        logic [2:0]       last;
        logic             mpr_en;
        logic [7:0]       modcnt;
        logic             zql;
        logic [DQ_W-1:0]  dq;
        logic             oe;
        logic             ard;
        logic             awr;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Read latency from AL and CL in the mode registers.
    function automatic logic [15:0] rl_of(input logic [13:0] m0, input logic [13:0] m1);
        logic [4:0] cl;
        logic [4:0] al;
        cl = {1'b0, m0[6:4]} + 5'h05 + {4'h0, m0[2]};
        al = (m1[4:3] == 2'h1) ? cl - 5'h01 : (m1[4:3] == 2'h2) ? cl - 5'h02 : 5'h00;
        rl_of = {11'h000, cl + al};
    endfunction

    logic redir;
    logic fmt_ok;
    logic [7:0] pat;
    assign fmt_ok = (s_q.mr[3][1:0] == MPR_FMT_PAT);
    assign redir  = s_q.mpr_en && (s_q.modcnt == 8'h00);
    assign pat    = MPR_PATTERN;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ard = 1'b0;
        s_d.awr = 1'b0;
        if (s_q.modcnt != 8'h00) begin
            s_d.modcnt = s_q.modcnt - 8'h01;
        end
        case (s_q.st)
            ST_IDLE: begin
                s_d.oe = 1'b0;
                s_d.dq = '0;
                if (cmd == CMD_MRS && ba[2] == 1'b0) begin
                    s_d.mr[ba[1:0]] = addr;
                    // readout enable tracks MR3 bit 2
                    if (ba == BA_MR3) begin
                        s_d.mpr_en = addr[MR3_EN_BIT];
                        s_d.modcnt = 8'(TMOD_CYC);
                    end
                end else if (cmd == CMD_ZQ) begin
                    s_d.st  = ST_ZQ;
                    s_d.zql = addr[A_ZQL_BIT];
                    s_d.cnt = addr[A_ZQL_BIT] ? 16'(ZQL_CYC - 1) : 16'(ZQS_CYC - 1);
                end else if (cmd == CMD_RD) begin
                    if (redir) begin
                        s_d.cnt = rl_of(s_q.mr[0], s_q.mr[1]) - 16'h0001;
                        s_d.st  = ST_WAIT;
                        if (!addr[A_BC_BIT]) begin
                            s_d.beat = {addr[A_NIB_BIT], 2'b00};
                            s_d.last = {addr[A_NIB_BIT], 2'b11};
                        end else begin
                            s_d.beat = 3'h0;
                            s_d.last = 3'h7;
                        end
                    end else begin
                        s_d.ard = 1'b1;
                    end
                // writes go to the array only outside readout
                end else if (cmd == CMD_WR && !s_q.mpr_en) begin
                    s_d.awr = 1'b1;
                end
            end
            ST_WAIT: begin
                s_d.cnt = s_q.cnt - 16'h0001;
                if (s_q.cnt == 16'h0000) begin
                    s_d.st = ST_BURST;
                end
            end
            ST_BURST: begin
                s_d.oe = fmt_ok;
                // beat n carries pattern bit n
                // prime line per byte or every line
                for (int i = 0; i < DQ_W; i++) begin
                    s_d.dq[i] = fmt_ok && (all_lines || (i % 8 == 0)) && pat[s_q.beat];
                end
                s_d.beat = s_q.beat + 3'h1;
                if (s_q.beat == s_q.last) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_ZQ: begin
                s_d.cnt = s_q.cnt - 16'h0001;
                if (s_q.cnt == 16'h0000) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs from the state record.
    assign dq_out         = s_q.dq;
    assign dq_oe          = s_q.oe;
    assign readout_active = redir;
    assign array_read     = s_q.ard;
    assign array_write    = s_q.awr;
    assign zq_busy        = (s_q.st == ST_ZQ);
    assign zq_long        = s_q.zql;
    assign mr0_val        = s_q.mr[0];
    assign mr1_val        = s_q.mr[1];
    assign mr2_val        = s_q.mr[2];
    assign mr3_val        = s_q.mr[3];

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_mr3_load: assert property (cmd == CMD_MRS && ba == BA_MR3 |=> mr3_val == $past(addr))
        else $error("MR3 not loaded");
    a_mr_select: assert property (cmd == CMD_MRS && ba == BA_MR0 |=> mr0_val == $past(addr))
        else $error("MR0 not loaded");
    a_enable_mod: assert property (cmd == CMD_MRS && ba == BA_MR3 && addr[2] |=> !readout_active)
        else $error("readout before tMOD");
    a_exit_array: assert property (cmd == CMD_MRS && ba == BA_MR3 && !addr[2] |=> !readout_active)
        else $error("readout not left");
    a_beat_lsb: assert property (s_q.st == ST_BURST && fmt_ok |=> dq_out[0] == MPR_PATTERN[$past(s_q.beat)] && dq_oe)
        else $error("pattern beat wrong");
    a_bc4_len: assert property (s_q.st == ST_WAIT && s_q.cnt == 0 && s_q.last[1:0] == 2'h3
                                && s_q.beat[1:0] == 2'h0 && s_q.last[2] == s_q.beat[2]
                                |=> (s_q.st == ST_BURST) [*4] ##1 s_q.st == ST_IDLE)
        else $error("chopped burst length");
    a_reserved_fmt: assert property (s_q.st == ST_BURST && !fmt_ok |=> !dq_oe)
        else $error("reserved format drove");
    a_prime_low: assert property (dq_oe && !$past(all_lines) |-> dq_out[DQ_W-1:1] == '0 || DQ_W > 8)
        else $error("non-prime line high");
    a_zq_busy: assert property (cmd == CMD_ZQ && s_q.st == ST_IDLE |=> zq_busy [*8])
        else $error("calibration too short");
    a_no_wr: assert property (readout_active && cmd == CMD_WR |=> !array_write)
        else $error("write during readout");
    c_bl8: cover property (s_q.st == ST_BURST && s_q.beat == 3'h7);
    c_bc4_hi: cover property (s_q.st == ST_BURST && s_q.beat == 3'h4 && s_q.last == 3'h7);
    c_zql: cover property (zq_busy && zq_long);
endmodule
`default_nettype wire

// ---- rtl/ddr3_calib_pkg.sv ----
// Package of constants and types for the DDR3 calibration and command block.
`default_nettype none
package ddr3_calib_pkg;
    // ------------------------------------------------------------------
    // Command encodings as {cs_n, ras_n, cas_n, we_n}.
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_ZQ   = 4'h6;
    localparam logic [3:0] CMD_NOP  = 4'h7;
    // ------------------------------------------------------------------
    // Mode register select codes and field positions.
    // ------------------------------------------------------------------
    localparam logic [2:0] BA_MR0   = 3'h0;
    localparam logic [2:0] BA_MR1   = 3'h1;
    localparam logic [2:0] BA_MR2   = 3'h2;
    localparam logic [2:0] BA_MR3   = 3'h3;
    localparam int         MR3_EN_BIT  = 2;
    localparam logic [1:0] MPR_FMT_PAT = 2'h0;
    localparam int         A_BC_BIT    = 12;
    localparam int         A_ZQL_BIT   = 10;
    localparam int         A_NIB_BIT   = 2;
    localparam logic [7:0] MPR_PATTERN = 8'haa;
    localparam logic [13:0] MR_RST     = 14'h0000;
    // ------------------------------------------------------------------
    // Timing: times in ns and derived cycle counts at 40 MHz.
    // ------------------------------------------------------------------
    localparam int CLK_PS       = 25000;
    localparam int TMOD_NS      = 15;
    localparam int TMOD_CYC     = (TMOD_NS * 1000 + CLK_PS - 1) / CLK_PS < 12 ? 12
                                : (TMOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int TZQINIT_CYC  = 512;
    localparam int TZQOPER_CYC  = 256;
    localparam int TZQCS_CYC    = 64;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BURST = 2'b10,
        ST_ZQ   = 2'b11
    } seq_t;
endpackage
`default_nettype wire
